// File: ccs_ctrl.sv
/*
 * Codec control block: serial command interpreter, register storage,
 * signaling pins, debounced change interrupts, ring and auxiliary clocks.
 * Assumes the host drives chip select, serial clock and data asynchronously;
 * all pins except rstn are synchronised to clk before use.
 */
`timescale 1ns/1ps
module ccs_ctrl #(
  parameter int MS_CYCLES = ccs_pkg::MS_CYCLES,
  // Identification value is arbitrary.
  parameter logic [7:0] ID_BYTE = 8'h5a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial control port
  input wire logic cs_n,
  input wire logic serial_clock_in,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Frame bit clock
  input wire logic frame_bit_clock_in,
  // Signaling pins
  input wire logic [ccs_pkg::NCH-1:0] line_sense_in_a,
  input wire logic [ccs_pkg::NCH-1:0] line_sense_in_b,
  output logic [ccs_pkg::NCH-1:0] line_drive_out_a,
  output logic [ccs_pkg::NCH-1:0] line_drive_out_b,
  input wire logic [ccs_pkg::NCH-1:0] line_bidir_a_i,
  output logic [ccs_pkg::NCH-1:0] line_bidir_a_o,
  output logic [ccs_pkg::NCH-1:0] line_bidir_a_oe,
  input wire logic [ccs_pkg::NCH-1:0] line_bidir_b_i,
  output logic [ccs_pkg::NCH-1:0] line_bidir_b_o,
  output logic [ccs_pkg::NCH-1:0] line_bidir_b_oe,
  input wire logic [ccs_pkg::NCH-1:0] line_bidir_c_i,
  output logic [ccs_pkg::NCH-1:0] line_bidir_c_o,
  output logic [ccs_pkg::NCH-1:0] line_bidir_c_oe,
  // Interrupts and special outputs
  output logic irq_channels_low,
  output logic irq_channels_high,
  output logic ring_wave_out,
  output logic aux_clock_out
);
  localparam int NCH = ccs_pkg::NCH;
  localparam int SW = 4 + 5 * NCH;
  // Chip select and serial clock reset to their idle high level, so no false edge follows reset.
  localparam logic [SW-1:0] SYNC_RST = {{(SW - 2){1'b0}}, 2'b11};

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic dcl_s;
  logic [NCH-1:0] sa_s;
  logic [NCH-1:0] sb_s;
  logic [NCH-1:0] ba_s;
  logic [NCH-1:0] bb_s;
  logic [NCH-1:0] bc_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {line_bidir_c_i, line_bidir_b_i, line_bidir_a_i, line_sense_in_b,
                  line_sense_in_a, frame_bit_clock_in, din, serial_clock_in, cs_n};
      sync2_r <= sync1_r;
    end
  end
  assign {bc_s, bb_s, ba_s, sb_s, sa_s, dcl_s, din_s, sclk_s, cs_s} = sync2_r;

  // ----------------------------------------------------------------------
  // Edge detection and timers
  // ----------------------------------------------------------------------
  logic sclk_q_r;
  logic dcl_q_r;
  logic sclk_rise;
  logic sclk_fall;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_r;
  logic ms_tick;
  logic [$clog2(ccs_pkg::DCL_TIMEOUT_CYC + 1)-1:0] dcl_cnt_r;
  logic dcl_ok_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclk_q_r <= 1'b1;
      dcl_q_r <= 1'b0;
    end else begin
      sclk_q_r <= sclk_s;
      dcl_q_r <= dcl_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_q_r;
  assign sclk_fall = ~sclk_s & sclk_q_r;

  always_ff @(posedge clk) begin
    if (!rstn || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end
  assign ms_tick = (ms_cnt_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

  // The bit clock counts as present while its edges come within the timeout.
  // bit clock watchdog
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dcl_cnt_r <= '0;
      dcl_ok_r <= 1'b0;
    end else if (dcl_s != dcl_q_r) begin
      dcl_cnt_r <= '0;
      dcl_ok_r <= 1'b1;
    end else if (dcl_cnt_r == ($bits(dcl_cnt_r))'(ccs_pkg::DCL_TIMEOUT_CYC)) begin
      dcl_ok_r <= 1'b0;
    end else begin
      dcl_cnt_r <= dcl_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] cr_r [NCH][ccs_pkg::CR_PER_CH];
  logic [7:0] xr_r [ccs_pkg::XR_NUM];
  logic [7:0] coef_r [NCH][ccs_pkg::COEF_DEPTH];

  // class from bits 4 and 3
  function automatic ccs_pkg::ccs_cmd_t dec_cmd(input logic [7:0] b);
    ccs_pkg::ccs_cmd_t c;
    c.cls = !b[ccs_pkg::CMD_CLS_HI] ? ccs_pkg::CLS_COEF :
            b[ccs_pkg::CMD_CLS_LO] ? ccs_pkg::CLS_EXT : ccs_pkg::CLS_STATUS;
    c.rd = b[ccs_pkg::CMD_RD_BIT];
    c.last = (c.cls == ccs_pkg::CLS_STATUS) ? {1'b0, b[1:0]} : b[2:0];
    c.ch = b[7:6];
    return c;
  endfunction

  // Ext registers 0 and 1 return the live pins, register 3 live c pins over stored direction; the rest return storage.
  function automatic logic [7:0] rd_byte(input ccs_pkg::ccs_cmd_t c, input logic [2:0] i);
    logic [7:0] v;
    v = ccs_pkg::REG_RST;
    case (c.cls)
      ccs_pkg::CLS_STATUS: v = cr_r[c.ch][i];
      ccs_pkg::CLS_COEF: v = coef_r[c.ch][i];
      default: begin
        if (i == ccs_pkg::XR_SIG) v = {sb_s, sa_s};
        else if (i == ccs_pkg::XR_BLO_DAT) v = {bb_s, ba_s};
        else if (i == ccs_pkg::XR_BC) v = {bc_s, xr_r[ccs_pkg::XR_BC][NCH-1:0]};
        else v = xr_r[i];
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Serial command engine
  // ----------------------------------------------------------------------
  ccs_pkg::ccs_state_t st_r;
  ccs_pkg::ccs_cmd_t cmd_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_cnt_r;
  logic [2:0] idx_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic id_phase_r;
  logic [7:0] rx_byte;
  logic wr_stb;
  logic ld_now;
  logic [2:0] ld_idx;
  logic rd_clr;
  ccs_pkg::ccs_cmd_t cmd_nxt;

  assign rx_byte = {rx_sh_r[6:0], din_s};
  assign cmd_nxt = dec_cmd(rx_byte);
  assign wr_stb = (st_r == ccs_pkg::ST_WR) && !cs_s && sclk_rise && (rx_cnt_r == 3'h7);
  assign ld_now = (st_r == ccs_pkg::ST_RD) && !cs_s && sclk_fall && (tx_cnt_r == 3'h7)
                  && (id_phase_r || idx_r != 3'h0);
  assign ld_idx = id_phase_r ? idx_r : idx_r - 3'h1;
  assign rd_clr = ld_now && (cmd_r.cls == ccs_pkg::CLS_EXT) && (ld_idx == ccs_pkg::XR_SIG
                  || ld_idx == ccs_pkg::XR_BLO_DAT || ld_idx == ccs_pkg::XR_BC);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ccs_pkg::ST_CMD;
      cmd_r <= '{cls: ccs_pkg::CLS_STATUS, rd: 1'b0, last: 3'h0, ch: 2'h0};
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      idx_r <= 3'h0;
      tx_sh_r <= 8'hff;
      tx_cnt_r <= 3'h0;
      id_phase_r <= 1'b0;
    end else if (cs_s) begin
      st_r <= ccs_pkg::ST_CMD;
      rx_cnt_r <= 3'h0;
      tx_cnt_r <= 3'h0;
    end else begin
      case (st_r)
        ccs_pkg::ST_CMD: begin
          if (sclk_rise) begin
            rx_sh_r <= rx_byte;
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == 3'h7) begin
              cmd_r <= cmd_nxt;
              idx_r <= cmd_nxt.last;
              tx_sh_r <= ID_BYTE;
              tx_cnt_r <= 3'h0;
              id_phase_r <= 1'b1;
              st_r <= cmd_nxt.rd ? ccs_pkg::ST_RD : ccs_pkg::ST_WR;
            end
          end
        end
        ccs_pkg::ST_WR: begin
          if (sclk_rise) begin
            rx_sh_r <= rx_byte;
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == 3'h7) begin
              if (idx_r == 3'h0) st_r <= ccs_pkg::ST_END;
              else idx_r <= idx_r - 3'h1;
            end
          end
        end
        ccs_pkg::ST_RD: begin
          if (sclk_fall) begin
            tx_cnt_r <= tx_cnt_r + 3'h1;
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
            if (ld_now) begin
              tx_sh_r <= rd_byte(cmd_r, ld_idx);
              idx_r <= ld_idx;
              id_phase_r <= 1'b0;
            end else if (tx_cnt_r == 3'h7) begin
              st_r <= ccs_pkg::ST_END;
            end
          end
        end
        ccs_pkg::ST_END: st_r <= ccs_pkg::ST_END;
        default: st_r <= ccs_pkg::ST_CMD;
      endcase
    end
  end

  // The output releases on the falling edge after the last bit has stood a full bit.
  // idle output on writes
  always_ff @(posedge clk) begin
    if (!rstn || cs_s) begin
      dout <= 1'b1;
      dout_oe <= 1'b0;
    end else if (sclk_fall) begin
      if (st_r == ccs_pkg::ST_RD) begin
        dout <= tx_sh_r[7];
        dout_oe <= 1'b1;
      end else begin
        dout <= 1'b1;
        dout_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        for (int r = 0; r < ccs_pkg::CR_PER_CH; r++) cr_r[c][r] <= ccs_pkg::REG_RST;
        for (int r = 0; r < ccs_pkg::COEF_DEPTH; r++) coef_r[c][r] <= ccs_pkg::REG_RST;
      end
      for (int r = 0; r < ccs_pkg::XR_NUM; r++) xr_r[r] <= ccs_pkg::REG_RST;
    end else if (wr_stb) begin
      case (cmd_r.cls)
        ccs_pkg::CLS_STATUS: cr_r[cmd_r.ch][idx_r] <= rx_byte;
        ccs_pkg::CLS_COEF: coef_r[cmd_r.ch][idx_r] <= rx_byte;
        default: xr_r[idx_r] <= rx_byte;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Signaling pins
  // ----------------------------------------------------------------------
  // per-channel line set
  assign line_drive_out_a = xr_r[ccs_pkg::XR_SIG][NCH-1:0];
  assign line_drive_out_b = xr_r[ccs_pkg::XR_SIG][2*NCH-1:NCH];
  assign line_bidir_a_o = xr_r[ccs_pkg::XR_BLO_DAT][NCH-1:0];
  assign line_bidir_b_o = xr_r[ccs_pkg::XR_BLO_DAT][2*NCH-1:NCH];
  assign line_bidir_a_oe = xr_r[ccs_pkg::XR_BLO_DIR][NCH-1:0];
  assign line_bidir_b_oe = xr_r[ccs_pkg::XR_BLO_DIR][2*NCH-1:NCH];
  assign line_bidir_c_o = xr_r[ccs_pkg::XR_BC][2*NCH-1:NCH];
  assign line_bidir_c_oe = xr_r[ccs_pkg::XR_BC][NCH-1:0];

  // ----------------------------------------------------------------------
  // Change interrupts
  // ----------------------------------------------------------------------
  logic [NCH-1:0] ba_in;
  logic [NCH-1:0] bb_in;
  logic [NCH-1:0] bc_in;
  logic chg_lo;
  logic chg_hi;
  logic irq_lo_r;
  logic irq_hi_r;

  // Pins set as outputs are masked so that own drive raises no interrupt.
  assign ba_in = ba_s & ~line_bidir_a_oe;
  assign bb_in = bb_s & ~line_bidir_b_oe;
  assign bc_in = bc_s & ~line_bidir_c_oe;

  ccs_debounce #(.W(10)) u_deb_lo (
    .clk(clk),
    .rstn(rstn),
    .raw({sa_s[1:0], sb_s[1:0], ba_in[1:0], bb_in[1:0], bc_in[1:0]}),
    .tick(ms_tick),
    .limit(xr_r[ccs_pkg::XR_DBR][3:0]),
    .change(chg_lo)
  );
  ccs_debounce #(.W(10)) u_deb_hi (
    .clk(clk),
    .rstn(rstn),
    .raw({sa_s[3:2], sb_s[3:2], ba_in[3:2], bb_in[3:2], bc_in[3:2]}),
    .tick(ms_tick),
    .limit(xr_r[ccs_pkg::XR_DBR][3:0]),
    .change(chg_hi)
  );

  // A change in the very cycle of a clearing read keeps the interrupt set.
  // set on change
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_lo_r <= 1'b0;
      irq_hi_r <= 1'b0;
    end else begin
      irq_lo_r <= chg_lo | (irq_lo_r & ~rd_clr);
      irq_hi_r <= chg_hi | (irq_hi_r & ~rd_clr);
    end
  end
  assign irq_channels_low = irq_lo_r;
  assign irq_channels_high = irq_hi_r;

  // ----------------------------------------------------------------------
  // Ring and auxiliary clock
  // ----------------------------------------------------------------------
  ccs_tonegen u_tone (
    .clk(clk),
    .rstn(rstn),
    .tick(ms_tick),
    .dcl_ok(dcl_ok_r),
    .ring_sel(xr_r[ccs_pkg::XR_DBR][7:4]),
    .aux_sel(xr_r[ccs_pkg::XR_AUX][1:0]),
    .ring_out(ring_wave_out),
    .aux_out(aux_clock_out)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  irq_set_a: assert property (@(posedge clk) disable iff (!rstn)
    chg_lo |=> irq_channels_low)
    else $error("low interrupt not raised on change");
  irq_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    rd_clr && !chg_lo && !chg_hi |=> !irq_channels_low && !irq_channels_high)
    else $error("interrupt not cleared by read");
  irq_high_a: assert property (@(posedge clk) disable iff (!rstn)
    chg_hi |=> irq_channels_high)
    else $error("high interrupt not raised on change");
  write_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ccs_pkg::ST_WR |-> !dout_oe && dout)
    else $error("serial output active during write");
  id_load_a: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ccs_pkg::ST_CMD && !cs_s && sclk_rise && rx_cnt_r == 3'h7
    && rx_byte[ccs_pkg::CMD_RD_BIT] |=> st_r == ccs_pkg::ST_RD && tx_sh_r == ID_BYTE)
    else $error("read command did not load identification");
  drive_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_stb && cmd_r.cls == ccs_pkg::CLS_EXT && idx_r == ccs_pkg::XR_SIG
    |=> line_drive_out_a == $past(rx_byte[3:0]) && line_drive_out_b == $past(rx_byte[7:4]))
    else $error("drive outputs not updated by write");
  write_order_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_stb && idx_r != 3'h0 |=> idx_r == $past(idx_r) - 3'h1)
    else $error("write index did not step down");
  read_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    st_r == ccs_pkg::ST_RD && !cs_s |=> st_r != ccs_pkg::ST_CMD)
    else $error("new command accepted during read");
  dcl_lost_a: assert property (@(posedge clk) disable iff (!rstn)
    dcl_s == dcl_q_r [*8] ##1 dcl_s == dcl_q_r [*8] ##1 dcl_s == dcl_q_r [*8]
    ##0 dcl_cnt_r == ($bits(dcl_cnt_r))'(ccs_pkg::DCL_TIMEOUT_CYC) |=> !dcl_ok_r)
    else $error("bit clock loss not detected");
endmodule

// File: ccs_ctrl_bench.sv
/*
 * Self-checking bench of the codec control block.
 * Assumes the host model for all serial traffic; bidir pins pulled to 0.
 */
`timescale 1ns/1ps
module ccs_ctrl_bench;
  localparam int MSC = 40;
  logic clk = 0, rstn = 0, fbc = 0, fbc_en = 1, oe_seen = 0;
  logic [1:0] fc = 0;
  logic [3:0] sa = 0, sb = 0;
  wire cs_n, sclk, din;
  logic dout, dout_oe, irq_lo, irq_hi, ring, aux;
  logic [3:0] da, db, ao, aoe, bo, boe, co, coe;
  logic [7:0] wd [8];
  logic [7:0] rd [9];
  logic [7:0] wc [2] = '{8'h51, 8'h03};
  int failures = 0, num_checks = 0, cnt, hits;
  int khz [3] = '{256, 512, 16384};
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    fc <= fc + 2'h1;
    if (fc == 2'h3 && fbc_en) fbc <= ~fbc;
    if (dout_oe === 1'b1) oe_seen <= 1'b1;
  end
  ccs_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  ccs_ctrl #(.MS_CYCLES(MSC)) dut_u (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .serial_clock_in(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .frame_bit_clock_in(fbc), .line_sense_in_a(sa), .line_sense_in_b(sb),
    .line_drive_out_a(da), .line_drive_out_b(db), .line_bidir_a_i(ao & aoe),
    .line_bidir_a_o(ao), .line_bidir_a_oe(aoe), .line_bidir_b_i(bo & boe),
    .line_bidir_b_o(bo), .line_bidir_b_oe(boe), .line_bidir_c_i(co & coe),
    .line_bidir_c_o(co), .line_bidir_c_oe(coe), .irq_channels_low(irq_lo),
    .irq_channels_high(irq_hi), .ring_wave_out(ring), .aux_clock_out(aux));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_in(input int g, input int lo, input int hi);
    num_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wd = '{8'h00, 8'h00, 8'h6c, 8'h0f, 8'ha5, 8'h3c, 0, 0};
    host_u.access(8'h1d, 6, wd, rd);
    chk({db, da}, 8'h3c);
    chk({bo, ao}, 8'ha5);
    chk({boe, aoe}, 8'h0f);
    chk({co, coe}, 8'h6c);
    chk({7'h0, oe_seen}, 8'h00);
    $display("test write done");
    sa <= 4'h1;
    repeat (12) @(posedge clk);
    chk({irq_hi, irq_lo}, 8'h01);
    host_u.access(8'h39, 2, wd, rd);
    chk(rd[0], 8'h5a);
    chk({7'h0, oe_seen}, 8'h01);
    chk(rd[1], 8'h05);
    chk(rd[2], 8'h01);
    chk({irq_hi, irq_lo}, 8'h00);
    sb <= 4'h8;
    repeat (12) @(posedge clk);
    chk({irq_hi, irq_lo}, 8'h02);
    host_u.access(8'h38, 1, wd, rd);
    chk({irq_hi, irq_lo}, 8'h00);
    $display("test irq done");
    for (int i = 0; i < 2; i++) begin
      wd = '{8'h11, 8'h22, 8'h33, 8'h44, 0, 0, 0, 0};
      host_u.access(wc[i], i * 2 + 2, wd, rd);
      host_u.access(wc[i] | 8'h20, i * 2 + 2, wd, rd);
      for (int k = 1; k <= i * 2 + 2; k++) chk(rd[k], wd[k-1]);
    end
    host_u.access(8'h31, 2, wd, rd);
    chk(rd[1] | rd[2], 8'h00);
    $display("test classes done");
    cnt = 0;
    @(posedge ring);
    while (ring === 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    chk_in(cnt, MSC + 1, MSC + 1);
    // 4000 sample intervals span 100 us, so rising edges are about kHz / 10.
    for (int s = 0; s < 3; s++) begin
      wd[0] = 8'(s);
      host_u.access(8'h1d, 6, wd, rd);
      hits = 0;
      cnt = 1;
      for (int k = 0; k <= 4000; k++) begin
        @(negedge clk);
        if (aux === 1'b1 && cnt == 0) hits++;
        cnt = (aux === 1'b1);
      end
      chk_in(hits, khz[s] / 10, khz[s] / 10 + 1);
    end
    @(posedge clk);
    fbc_en <= 1'b0;
    repeat (200) @(posedge clk);
    hits = 0;
    repeat (100) @(negedge clk) hits += (ring !== 1'b0 || aux !== 1'b0);
    chk_in(hits, 0, 0);
    $display("test tones done");
    report_and_stop();
  end
endmodule

// File: ccs_debounce.sv
/*
 * Debounce of a group of signaling lines; pulses once per accepted change.
 * Assumes synchronised inputs and a one-cycle millisecond tick.
 */
`timescale 1ns/1ps
module ccs_debounce #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Lines and timing
  input wire logic [W-1:0] raw,
  input wire logic tick,
  input wire logic [3:0] limit,
  // Result
  output logic change
);
  logic [W-1:0] last_r;
  logic [W-1:0] stable_r;
  logic [3:0] cnt_r;
  logic [1:0] primed_r;

  // The first three cycles after reset adopt the lines, so that the pin
  // synchronisers have filled and power-up levels count as no change.
  // stability before interrupt
  always_ff @(posedge clk) begin
    if (!rstn) begin
      last_r <= '0;
      stable_r <= '0;
      cnt_r <= 4'h0;
      primed_r <= 2'h0;
      change <= 1'b0;
    end else begin
      last_r <= raw;
      change <= 1'b0;
      if (!(&primed_r)) begin
        stable_r <= raw;
        primed_r <= primed_r + 2'h1;
      end else if (raw != last_r) begin
        cnt_r <= 4'h0;
      end else if (raw != stable_r) begin
        if (cnt_r >= limit) begin
          stable_r <= raw;
          change <= 1'b1;
          cnt_r <= 4'h0;
        end else if (tick) begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

  stable_first_a: assert property (@(posedge clk) disable iff (!rstn)
    &primed_r && raw != last_r |=> !change)
    else $error("change reported while lines still moving");
endmodule

// File: ccs_host.sv
/*
 * Host model on the serial control port: frames, command, data bytes.
 * Assumes the caller enters a task just after a rising edge of clk.
 */
`timescale 1ns/1ps
module ccs_host (
  // Clock
  input wire logic clk,
  // Serial port
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b1;
  end
  // Shift on fall, sample after rise.
  // While reading, din toggles each bit so stray sampling shows.
  task automatic xbyte(input logic [7:0] b, input logic rd, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= rd ? ~din : b[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      @(posedge clk);
      r[i] = dout;
      repeat (3) @(posedge clk);
    end
  endtask
  // Command, bytes, then chip select high.
  task automatic access(input logic [7:0] cmd, input int n,
      input logic [7:0] wd [8], output logic [7:0] rd [9]);
    logic [7:0] junk;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    xbyte(cmd, 1'b0, junk);
    for (int k = 0; k <= n; k++) begin
      if (cmd[5]) xbyte(8'h00, 1'b1, rd[k]);
      else if (k < n) xbyte(wd[k], 1'b0, junk);
    end
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// File: ccs_pkg.sv
/*
 * Shared constants, field positions, timing counts and types of the codec
 * control block: serial command port, signaling pins, interrupts, ring wave
 * and auxiliary clock.
 * Assumes a single 40 MHz system clock and four voice channels.
 */
// Function
// - Per channel: two sense, two drive, three bidir.
// - Ext reg 0: read sense, write drive.
// - Ext reg 1 bidir a/b data, reg 2 direction.
// - Ext reg 3: pin c data high, direction low.
// - Debounced change on channels 1-2 raises interrupt.
// - Reading ext regs 0,1,3 clears interrupt.
// - Channels 3-4 drive the second interrupt.
// - Ring square wave, 2 to 28 ms.
// - Aux clock: 256, 512 or 16384 kHz.
// - Ring and aux run only with bit clock.
// - First byte decoded; bits 4,3 pick class.
// - Every class reads or writes, carries count.
// - Write up to 8 bytes; read adds ID.
// - Status class: six registers per channel.
// - Extended class: eight shared registers.
// - Coefficient class: memory per channel.
// - Sample rising, shift falling, chip select ends.
// - Read sends ID then data, ignores input.
package ccs_pkg;
  // ----------------------------------------------------------------------
  // Sizes and layout
  // ----------------------------------------------------------------------
  localparam int NCH = 4;
  localparam int CR_PER_CH = 6;
  localparam int XR_NUM = 8;
  localparam int COEF_DEPTH = 8;
  localparam logic [2:0] XR_SIG = 3'h0;
  localparam logic [2:0] XR_BLO_DAT = 3'h1;
  localparam logic [2:0] XR_BLO_DIR = 3'h2;
  localparam logic [2:0] XR_BC = 3'h3;
  localparam logic [2:0] XR_DBR = 3'h4;
  localparam logic [2:0] XR_AUX = 3'h5;
  localparam int CMD_RD_BIT = 5;
  localparam int CMD_CLS_HI = 4;
  localparam int CMD_CLS_LO = 3;
  localparam logic [3:0] RING_MAX_SEL = 4'hd;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] AUX_SEL_256 = 2'h0;
  localparam logic [1:0] AUX_SEL_512 = 2'h1;
  localparam logic [1:0] AUX_SEL_16384 = 2'h2;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam longint CLK_HZ = 40000000;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int DCL_TIMEOUT_NS = 2000;
  localparam int DCL_TIMEOUT_CYC = DCL_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam longint AUX_256_HZ = 256000;
  localparam longint AUX_512_HZ = 512000;
  localparam longint AUX_16384_HZ = 16384000;
  localparam logic [31:0] AUX_INC_256 = 32'((AUX_256_HZ << 32) / CLK_HZ);
  localparam logic [31:0] AUX_INC_512 = 32'((AUX_512_HZ << 32) / CLK_HZ);
  localparam logic [31:0] AUX_INC_16384 = 32'((AUX_16384_HZ << 32) / CLK_HZ);
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_STATUS = 3'b001,
    CLS_EXT = 3'b010,
    CLS_COEF = 3'b100
  } ccs_cls_t;
  typedef struct packed {
    ccs_cls_t cls;
    logic rd;
    logic [2:0] last;
    logic [1:0] ch;
  } ccs_cmd_t;
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001,
    ST_WR = 4'b0010,
    ST_RD = 4'b0100,
    ST_END = 4'b1000
  } ccs_state_t;
endpackage

// File: ccs_tonegen.sv
/*
 * Ring square wave and auxiliary clock generator.
 * Assumes a millisecond tick and a bit clock presence flag from the caller.
 */
`timescale 1ns/1ps
module ccs_tonegen (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic tick,
  input wire logic dcl_ok,
  input wire logic [3:0] ring_sel,
  input wire logic [1:0] aux_sel,
  // Outputs
  output logic ring_out,
  output logic aux_out
);
  logic [3:0] ms_r;
  logic [3:0] half_sel;
  logic [31:0] acc_r;
  logic [31:0] inc;

  assign half_sel = (ring_sel > ccs_pkg::RING_MAX_SEL) ? ccs_pkg::RING_MAX_SEL : ring_sel;
  assign inc = (aux_sel == ccs_pkg::AUX_SEL_256) ? ccs_pkg::AUX_INC_256 :
               (aux_sel == ccs_pkg::AUX_SEL_512) ? ccs_pkg::AUX_INC_512 :
               (aux_sel == ccs_pkg::AUX_SEL_16384) ? ccs_pkg::AUX_INC_16384 : 32'h0000_0000;

  // Half period is sel+1 ms, so the full period spans 2 to 28 ms.
  // equal high and low
  always_ff @(posedge clk) begin
    if (!rstn || !dcl_ok) begin
      ms_r <= 4'h0;
      ring_out <= 1'b0;
    end else if (tick) begin
      if (ms_r >= half_sel) begin
        ms_r <= 4'h0;
        ring_out <= ~ring_out;
      end else begin
        ms_r <= ms_r + 4'h1;
      end
    end
  end

  // A phase accumulator; 16384 kHz is not a divisor of the clock, so it jitters.
  // stopped without bit clock
  always_ff @(posedge clk) begin
    if (!rstn || !dcl_ok) begin
      acc_r <= 32'h0000_0000;
      aux_out <= 1'b0;
    end else begin
      acc_r <= acc_r + inc;
      aux_out <= acc_r[31];
    end
  end

  gen_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    !dcl_ok |=> !ring_out && !aux_out)
    else $error("ring or aux output running without bit clock");
  ring_step_a: assert property (@(posedge clk) disable iff (!rstn)
    dcl_ok && !tick ##1 dcl_ok |-> $stable(ring_out))
    else $error("ring output changed between ticks");
endmodule
